//--- rtl/spr_pkg.sv
package spr_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [11:0] ADDR_LEVEL1   = 12'h000;
    localparam logic [11:0] ADDR_LEVEL2   = 12'h004;
    localparam logic [11:0] ADDR_LEVEL3   = 12'h008;
    localparam logic [11:0] ADDR_LEVEL4   = 12'h00C;
    localparam logic [11:0] ADDR_MAKE     = 12'h010;
    localparam logic [11:0] ADDR_BREAK    = 12'h014;
    localparam logic [11:0] ADDR_CONFIG   = 12'h018;
    localparam logic [11:0] ADDR_READING  = 12'h01C;
    localparam logic [11:0] ADDR_STATUS   = 12'h020;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h024;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h028;
    localparam logic [11:0] ADDR_PROMPT   = 12'h02C;

    // ==========================================================
    // Config field positions
    // ==========================================================
    localparam int CFG_PAT_LSB   = 0;
    localparam int CFG_BAND_BIT  = 2;
    localparam int CFG_NUMERIC_DISPLAY_ON_BIT  = 3;
    localparam int CFG_BRITE_LSB = 4;
    localparam int CFG_FIT_LSB   = 8;

    // ==========================================================
    // Value ranges and reset values
    // ==========================================================
    localparam logic signed [15:0] LEVEL_MIN   = -16'sd1999;
    localparam logic signed [15:0] LEVEL_MAX   = 16'sd9999;
    localparam logic [13:0]        DELAY_MAX   = 14'd9999;
    localparam logic signed [15:0] LEVEL_RST   = 16'sd9999;
    localparam logic [1:0]         BRITE_RST   = 2'd3;

    // ==========================================================
    // Polarity pattern codes; in the decoded mask, bit i high means level i+1 activates above
    // ==========================================================
    localparam logic [1:0] PAT_LLLL = 2'd0;
    localparam logic [1:0] PAT_LHLH = 2'd1;
    localparam logic [1:0] PAT_LHHH = 2'd2;
    localparam logic [1:0] PAT_HHHH = 2'd3;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ       = 25_000_000;
    localparam int TICK_SEC     = 1;
    localparam int TICK_CYCLES  = CLK_HZ * TICK_SEC;

    // Prompt sequence while stepping through level programming
    typedef enum logic [8:0] {
        SPR_P_IDLE  = 9'b0_0000_0001,
        SPR_P_LVL1  = 9'b0_0000_0010,
        SPR_P_MAKE  = 9'b0_0000_0100,
        SPR_P_BRK   = 9'b0_0000_1000,
        SPR_P_BAND  = 9'b0_0001_0000,
        SPR_P_LVL2  = 9'b0_0010_0000,
        SPR_P_LVL3  = 9'b0_0100_0000,
        SPR_P_LVL4  = 9'b0_1000_0000,
        SPR_P_PAT   = 9'b1_0000_0000
    } spr_prompt_e;

endpackage

//--- rtl/spr_delay.sv
`timescale 1ns/1ps
// Make/break delay filter for the first trip level
module spr_delay (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        sample,
    input  wire logic        tick,
    input  wire logic        alarm,
    input  wire logic [13:0] make_delay,
    input  wire logic [13:0] break_delay,
    output logic             relay
);

    typedef struct packed {
        logic        relay;
        logic [13:0] secs;
    } spr_dly_s;

    spr_dly_s s_q;
    spr_dly_s s_d;

    // ==========================================================
    // Timer: counts seconds while the alarm differs from relay
    // ==========================================================
    always_comb begin
        s_d = s_q;
        if (alarm == s_q.relay) begin
            s_d.secs = '0;                              // Interruption restarts
        end else if (alarm && s_q.secs >= make_delay) begin
            s_d.relay = 1'b1;
            s_d.secs  = '0;
        end else if (!alarm && s_q.secs >= break_delay) begin
            s_d.relay = 1'b0;
            s_d.secs  = '0;
        end else if (tick && s_q.secs != 14'h3FFF) begin
            s_d.secs = s_q.secs + 14'd1;
        end
        if (!sample && !tick) begin
            s_d = s_q;                                  // Only act per reading/tick
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign relay = s_q.relay;

endmodule

//--- rtl/spr_top.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module spr_top (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reading_valid,
    input  wire logic [15:0] reading,
    input  wire logic        lock_n,
    input  wire logic        dim_n,
    input  wire logic        program_key,
    input  wire logic        view_key,
    output logic      [3:0]  relay_drive,
    output logic      [3:0]  lamp_drive,
    output logic      [1:0]  brightness,
    output logic             numeric_display_on,
    output logic      [8:0]  prompt,
    output logic             irq
);

    typedef struct packed {
        logic signed [15:0] first_trip_level;
        logic signed [15:0] second_trip_level;
        logic signed [15:0] third_trip_level;
        logic signed [15:0] fourth_trip_level;
        logic [13:0]        make_delay;
        logic [13:0]        break_delay;
        logic [1:0]         relay_polarity_pattern;
        logic               pump_band_enable;
        logic               display_enable;
        logic [1:0]         brite;
        logic [3:0]         fitted;
        logic signed [15:0] last_reading;
        logic               sample;
        logic               sample_dly;
        logic [24:0]        div;
        logic               tick;
        logic [3:0]         alarm;
        logic               band_on;
        logic [3:0]         irq_stat;
        logic [3:0]         irq_mask;
        logic               write_refused;
        spr_pkg::spr_prompt_e prompt;
        logic               pkey_d;
        logic               vkey_d;
        logic               viewing;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic [3:0]         relay;
        logic [3:0]         lamp;
        logic [1:0]         bright_out;
        logic               numeric_display_on_out;
        logic               irq;
    } spr_state_s;

    spr_state_s s_q;
    spr_state_s s_d;
    logic       level1_relay;
    logic [3:0] above;
    logic [3:0] below;
    logic [3:0] pol_high;
    logic signed [15:0] lvl [4];
    logic [3:0] events;

    // ==========================================================
    // Delay filter for the first level
    // ==========================================================
    spr_delay u_delay (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .sample      (s_q.sample_dly),
        .tick        (s_q.tick),
        .alarm       (s_q.band_on),
        .make_delay  (s_q.make_delay),
        .break_delay (s_q.break_delay),
        .relay       (level1_relay)
    );

    // Pattern decode: letters left to right are levels one to four
    always_comb begin
        case (s_q.relay_polarity_pattern)
            spr_pkg::PAT_LLLL: pol_high = 4'b0000;
            spr_pkg::PAT_LHLH: pol_high = 4'b1010;
            spr_pkg::PAT_LHHH: pol_high = 4'b1110;
            default:           pol_high = 4'b1111;
        endcase
    end

    assign lvl[0] = s_q.first_trip_level;
    assign lvl[1] = s_q.second_trip_level;
    assign lvl[2] = s_q.third_trip_level;
    assign lvl[3] = s_q.fourth_trip_level;

    // Strict comparisons: a level at the range extreme in its own polarity direction cannot trip on an in-range reading
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cmp
            assign above[gi] = s_q.last_reading > lvl[gi];
            assign below[gi] = s_q.last_reading < lvl[gi];
        end
    endgenerate

    assign events = s_d.lamp & ~s_q.lamp;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic        acc;
        logic        wr;
        logic        rd;
        logic        ok;
        logic signed [15:0] wv;
        logic [3:0]  clr;
        logic        band_mode;
        acc       = psel && penable && !s_q.pready;
        wr        = acc && pwrite;
        rd        = acc && !pwrite;
        ok        = lock_n;
        wv        = pwdata[15:0];
        clr       = '0;
        band_mode = 1'b0;
        s_d       = s_q;

        // One-second tick from the system clock
        s_d.tick = 1'b0;
        if (s_q.div == 25'(spr_pkg::TICK_CYCLES - 1)) begin
            s_d.div  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 25'd1;
        end

        // Capture each new conversion; comparisons use it next cycle
        s_d.sample = reading_valid;
        // Band state settles a cycle after the compare; strobe the filter then
        s_d.sample_dly = s_q.sample;
        if (reading_valid) begin
            s_d.last_reading = reading;
        end

        // Alarm comparisons against each level
        for (int i = 0; i < 4; i++) begin
            s_d.alarm[i] = pol_high[i] ? above[i] : below[i];
        end

        // Pump band on the first level, level two is the upper limit
        band_mode = s_q.pump_band_enable
                 && (s_q.second_trip_level > s_q.first_trip_level);
        if (!band_mode) begin
            s_d.band_on = s_d.alarm[0];
        end else if (s_q.relay_polarity_pattern == spr_pkg::PAT_LHLH) begin
            if (below[0]) begin
                s_d.band_on = 1'b1;
            end else if (s_q.last_reading >= s_q.second_trip_level) begin
                s_d.band_on = 1'b0;
            end
        end else if (s_q.relay_polarity_pattern == spr_pkg::PAT_HHHH) begin
            if (above[1]) begin
                s_d.band_on = 1'b1;
            end else if (s_q.last_reading <= s_q.first_trip_level) begin
                s_d.band_on = 1'b0;
            end
        end else begin
            s_d.band_on = s_d.alarm[0];
        end

        // Outputs: level one delayed, others direct; unfitted relays off
        s_d.lamp[0] = level1_relay;
        s_d.lamp[1] = s_q.alarm[1];
        s_d.lamp[2] = s_q.alarm[2];
        s_d.lamp[3] = s_q.alarm[3];
        s_d.relay   = s_d.lamp & s_q.fitted;

        // Prompt walk on the program key
        s_d.pkey_d = program_key;
        s_d.vkey_d = view_key;
        if (program_key && !s_q.pkey_d) begin
            case (s_q.prompt)
                spr_pkg::SPR_P_IDLE: s_d.prompt = spr_pkg::SPR_P_LVL1;
                spr_pkg::SPR_P_LVL1: s_d.prompt = spr_pkg::SPR_P_MAKE;
                spr_pkg::SPR_P_MAKE: s_d.prompt = spr_pkg::SPR_P_BRK;
                spr_pkg::SPR_P_BRK:  s_d.prompt = spr_pkg::SPR_P_BAND;
                spr_pkg::SPR_P_BAND: s_d.prompt = spr_pkg::SPR_P_LVL2;
                spr_pkg::SPR_P_LVL2: s_d.prompt = spr_pkg::SPR_P_LVL3;
                spr_pkg::SPR_P_LVL3: s_d.prompt = spr_pkg::SPR_P_LVL4;
                spr_pkg::SPR_P_LVL4: s_d.prompt = spr_pkg::SPR_P_PAT;
                default:             s_d.prompt = spr_pkg::SPR_P_IDLE;
            endcase
        end
        if (view_key && !s_q.vkey_d) begin
            s_d.viewing = !s_q.viewing;
        end

        // Display: halved by dim input, lit during any procedure
        s_d.bright_out = dim_n ? s_q.brite : (s_q.brite >> 1);
        s_d.numeric_display_on_out   = s_q.display_enable || s_q.viewing
                      || (s_q.prompt != spr_pkg::SPR_P_IDLE);

        // APB: one wait state, answer one cycle after access begins
        s_d.pready  = acc;
        s_d.pslverr = 1'b0;
        s_d.prdata  = '0;
        if (wr) begin
            s_d.write_refused = 1'b0;
            case (paddr)
                spr_pkg::ADDR_LEVEL1, spr_pkg::ADDR_LEVEL2,
                spr_pkg::ADDR_LEVEL3, spr_pkg::ADDR_LEVEL4: begin
                    if (!ok || wv < spr_pkg::LEVEL_MIN || wv > spr_pkg::LEVEL_MAX) begin
                        s_d.write_refused = 1'b1;
                        s_d.pslverr       = 1'b1;
                    end else if (paddr == spr_pkg::ADDR_LEVEL1) begin
                        s_d.first_trip_level = wv;
                    end else if (paddr == spr_pkg::ADDR_LEVEL2) begin
                        s_d.second_trip_level = wv;
                    end else if (paddr == spr_pkg::ADDR_LEVEL3) begin
                        s_d.third_trip_level = wv;
                    end else begin
                        s_d.fourth_trip_level = wv;
                    end
                end
                spr_pkg::ADDR_MAKE, spr_pkg::ADDR_BREAK: begin
                    if (!ok || pwdata[13:0] > spr_pkg::DELAY_MAX
                        || pwdata[31:14] != '0) begin
                        s_d.write_refused = 1'b1;
                        s_d.pslverr       = 1'b1;
                    end else if (paddr == spr_pkg::ADDR_MAKE) begin
                        s_d.make_delay = pwdata[13:0];
                    end else begin
                        s_d.break_delay = pwdata[13:0];
                    end
                end
                spr_pkg::ADDR_CONFIG: begin
                    if (!ok) begin
                        s_d.write_refused = 1'b1;
                        s_d.pslverr       = 1'b1;
                    end else begin
                        s_d.relay_polarity_pattern = pwdata[spr_pkg::CFG_PAT_LSB +: 2];
                        s_d.pump_band_enable       = pwdata[spr_pkg::CFG_BAND_BIT];
                        s_d.display_enable         = pwdata[spr_pkg::CFG_NUMERIC_DISPLAY_ON_BIT];
                        s_d.brite                  = pwdata[spr_pkg::CFG_BRITE_LSB +: 2];
                        s_d.fitted                 = pwdata[spr_pkg::CFG_FIT_LSB +: 4];
                    end
                end
                spr_pkg::ADDR_IRQ_STAT: clr = pwdata[3:0];
                spr_pkg::ADDR_IRQ_MASK: s_d.irq_mask = pwdata[3:0];
                spr_pkg::ADDR_READING, spr_pkg::ADDR_STATUS,
                spr_pkg::ADDR_PROMPT: ;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (rd) begin
            case (paddr)
                spr_pkg::ADDR_LEVEL1:   s_d.prdata = 32'(s_q.first_trip_level);
                spr_pkg::ADDR_LEVEL2:   s_d.prdata = 32'(s_q.second_trip_level);
                spr_pkg::ADDR_LEVEL3:   s_d.prdata = 32'(s_q.third_trip_level);
                spr_pkg::ADDR_LEVEL4:   s_d.prdata = 32'(s_q.fourth_trip_level);
                spr_pkg::ADDR_MAKE:     s_d.prdata = {18'h0, s_q.make_delay};
                spr_pkg::ADDR_BREAK:    s_d.prdata = {18'h0, s_q.break_delay};
                spr_pkg::ADDR_CONFIG:   s_d.prdata = {20'h0, s_q.fitted, 2'b00,
                                                      s_q.brite, s_q.display_enable,
                                                      s_q.pump_band_enable,
                                                      s_q.relay_polarity_pattern};
                spr_pkg::ADDR_READING:  s_d.prdata = 32'(s_q.last_reading);
                spr_pkg::ADDR_STATUS:   s_d.prdata = {22'h0, s_q.write_refused, !lock_n,
                                                      s_q.relay, s_q.lamp};
                spr_pkg::ADDR_IRQ_STAT: s_d.prdata = {28'h0, s_q.irq_stat};
                spr_pkg::ADDR_IRQ_MASK: s_d.prdata = {28'h0, s_q.irq_mask};
                spr_pkg::ADDR_PROMPT:   s_d.prdata = {23'h0, s_q.prompt};
                default:                s_d.pslverr = 1'b1;
            endcase
        end

        // Sticky lamp-rise flags; a new event wins over a clear
        s_d.irq_stat = (s_q.irq_stat & ~clr) | events;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q                        <= '0;
            s_q.first_trip_level       <= spr_pkg::LEVEL_RST;
            s_q.second_trip_level      <= spr_pkg::LEVEL_RST;
            s_q.third_trip_level       <= spr_pkg::LEVEL_RST;
            s_q.fourth_trip_level      <= spr_pkg::LEVEL_RST;
            s_q.relay_polarity_pattern <= spr_pkg::PAT_HHHH;
            s_q.display_enable         <= 1'b1;
            s_q.brite                  <= spr_pkg::BRITE_RST;
            s_q.fitted                 <= 4'hF;
            s_q.prompt                 <= spr_pkg::SPR_P_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata             = s_q.prdata;
    assign pready             = s_q.pready;
    assign pslverr            = s_q.pslverr;
    assign relay_drive        = s_q.relay;
    assign lamp_drive         = s_q.lamp;
    assign brightness         = s_q.bright_out;
    assign numeric_display_on = s_q.numeric_display_on_out;
    assign prompt             = s_q.prompt;
    assign irq                = s_q.irq;

endmodule

//--- dv/spr_top_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the trip-level controller
module spr_chk (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        reading_valid,
    input wire logic [15:0] reading,
    input wire logic        lock_n,
    input wire logic        dim_n,
    input wire logic        program_key,
    input wire logic        view_key,
    input wire logic [3:0]  relay_drive,
    input wire logic [3:0]  lamp_drive,
    input wire logic [1:0]  brightness,
    input wire logic        numeric_display_on,
    input wire logic [8:0]  prompt,
    input wire logic        irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] since_rv_q;
    // Cycles since the last reading or APB write, saturating so it never wraps back to small
    always_ff @(posedge sys_clk) begin
        if (!rst_n || reading_valid || (psel && penable && pwrite)) since_rv_q <= 4'h0;
        else if (since_rv_q != 4'hF) since_rv_q <= since_rv_q + 4'h1;
    end
    apb_wait_a: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    apb_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    lock_refuse_a: assert property (pready && psel && pwrite && !lock_n &&
        paddr <= spr_pkg::ADDR_CONFIG |-> pslverr) else $error("locked write taken");
    dim_half_a: assert property (!dim_n && !$past(dim_n) && !$past(dim_n, 2)
        |-> brightness <= 2'd1) else $error("dim not halved");
    prompt_hot_a: assert property ($onehot(prompt)) else $error("prompt not one-hot");
    prompt_step_a: assert property ($changed(prompt) && prompt != 9'h001
        |-> prompt == {$past(prompt[7:0]), 1'b0}) else $error("prompt order");
    relay_follow_a: assert property ((relay_drive[3:2] & ~lamp_drive[3:2]) == 2'b00)
        else $error("relay without lamp");
    lamp_read_a: assert property ($changed(lamp_drive[3:1]) |-> since_rv_q <= 4'd4)
        else $error("lamp moved without reading");
    cover property (pslverr);
    cover property (irq);
    cover property (relay_drive[0] && lamp_drive[0]);
    cover property (prompt == 9'h100);
endmodule

bind spr_top spr_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reading_valid(reading_valid), .reading(reading),
    .lock_n(lock_n), .dim_n(dim_n), .program_key(program_key), .view_key(view_key),
    .relay_drive(relay_drive), .lamp_drive(lamp_drive), .brightness(brightness),
    .numeric_display_on(numeric_display_on), .prompt(prompt), .irq(irq));

//--- dv/spr_load.sv
`timescale 1ns/1ps
// ==========================================================
// Relay coils and panel lamps; each picks up one cycle after its drive
module spr_load (
    input  wire logic       sys_clk,
    input  wire logic [3:0] relay_drive,
    input  wire logic [3:0] lamp_drive,
    output logic      [3:0] coil_q,
    output logic      [3:0] lit_q
);
    // No latching: a coil drops one cycle after its drive is removed
    always_ff @(posedge sys_clk) begin
        coil_q <= relay_drive;
        lit_q  <= lamp_drive;
    end
endmodule

//--- dv/spr_top_test.sv
`timescale 1ns/1ps
module spr_top_test;
    typedef struct packed { logic [31:0] exp; logic [31:0] msk; logic err; } spr_note_s;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    logic reading_valid = 0, lock_n = 1, dim_n = 1, program_key = 0, view_key = 0, numeric_display_on_on;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [15:0] reading = 0;
    logic [3:0] relay, lamp, coil, lit, hi, fit;
    logic [1:0] brite;
    logic [8:0] prompt;
    spr_note_s notes[$], cur;
    int fail_count = 0, n_checks = 0, cyc = 0, lv[4], v;
    spr_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reading_valid(reading_valid), .reading(reading),
        .lock_n(lock_n), .dim_n(dim_n), .program_key(program_key), .view_key(view_key),
        .relay_drive(relay), .lamp_drive(lamp), .brightness(brite),
        .numeric_display_on(numeric_display_on_on), .prompt(prompt), .irq(irq));
    spr_load load_u (.sys_clk(sys_clk), .relay_drive(relay), .lamp_drive(lamp),
        .coil_q(coil), .lit_q(lit));
    // ==========================================================
    // Shared tasks
    task chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One transfer; held until pready is seen, then an idle cycle
    task apb(logic wr, logic [11:0] a, logic [31:0] d, logic [31:0] e, logic [31:0] m,
             logic err);
        notes.push_back('{e, m, err});
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
    endtask
    task wr(logic [11:0] a, logic [31:0] d, logic err);
        apb(1'b1, a, d, 32'h0, 32'h0, err);
    endtask
    task rd(logic [11:0] a, logic [31:0] e, logic [31:0] m, logic err);
        apb(1'b0, a, 32'h0, e, m, err);
    endtask
    task rdg(int val);
        reading <= 16'(val); reading_valid <= 1;
        @(posedge sys_clk);
        reading_valid <= 0;
        repeat (8) @(posedge sys_clk);
    endtask
    task settle();
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    function automatic logic [3:0] exp_lamps(int val, logic [3:0] h);
        for (int i = 0; i < 4; i++) exp_lamps[i] = h[i] ? (val > lv[i]) : (val < lv[i]);
    endfunction
    // ==========================================================
    // Clock, timeout and answer monitor
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            end_of_test();
        end
    end
    // Each answer is matched against the oldest note of the driver
    always @(posedge sys_clk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) chk("unexpected pready", 32'h0, 32'h1);
            else begin
                cur = notes.pop_front();
                chk("prdata", cur.exp & cur.msk, prdata & cur.msk);
                chk("pslverr", 32'(cur.err), 32'(pslverr));
            end
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h1d70));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1;
        settle();
        chk("brightness", 32'd3, 32'(brite));
        @(posedge sys_clk);
        rd(spr_pkg::ADDR_LEVEL1, 32'd9999, 32'h0000_FFFF, 0);
        rd(12'h0FC, 32'h0, 32'hFFFF_FFFF, 1);
        wr(spr_pkg::ADDR_LEVEL1, 32'd10000, 1);
        wr(spr_pkg::ADDR_LEVEL2, 32'hFFFF_F830, 1);
        wr(spr_pkg::ADDR_MAKE, 32'd10000, 1);
        wr(spr_pkg::ADDR_MAKE, 32'd0, 0);
        wr(spr_pkg::ADDR_BREAK, 32'd0, 0);
        wr(spr_pkg::ADDR_IRQ_MASK, 32'h0000_000F, 0);
        // Every pattern; level four sits at the extreme matching its letter
        for (int p = 0; p < 4; p++) begin
            hi = (p == 0) ? 4'b0000 : (p == 1) ? 4'b1010 : (p == 2) ? 4'b1110 : 4'b1111;
            fit = (p == 3) ? 4'h3 : 4'hF;
            lv = '{1000, 3000, 5000, hi[3] ? 9999 : -1999};
            for (int i = 0; i < 4; i++) wr(spr_pkg::ADDR_LEVEL1 + 12'(4 * i), 32'(lv[i]), 0);
            wr(spr_pkg::ADDR_CONFIG, {20'h0, fit, 2'b0, 2'b11, 2'b10, 2'(p)}, 0);
            for (int k = 0; k < 4; k++) begin
                v = (k == 0) ? 9999 : (k == 1) ? -1999 : int'($urandom_range(11998)) - 1999;
                rdg(v);
                chk("lamps lit", 32'(exp_lamps(v, hi)), 32'(lit));
                chk("coils", 32'(exp_lamps(v, hi) & fit), 32'(coil));
                rd(spr_pkg::ADDR_STATUS, {24'h0, exp_lamps(v, hi) & fit, exp_lamps(v, hi)},
                   32'h0000_00FF, 0);
            end
        end
        settle();
        chk("irq raised", 32'h1, 32'(irq));
        @(posedge sys_clk);
        wr(spr_pkg::ADDR_IRQ_MASK, 32'h0, 0);
        settle();
        chk("irq masked", 32'h0, 32'(irq));
        @(posedge sys_clk);
        wr(spr_pkg::ADDR_IRQ_MASK, 32'h0000_000F, 0);
        wr(spr_pkg::ADDR_IRQ_STAT, 32'h0000_000F, 0);
        settle();
        chk("irq cleared", 32'h0, 32'(irq));
        @(posedge sys_clk);
        // Band mode: both filling and emptying give on, on, off, off
        for (int p = 1; p < 4; p += 2) begin
            wr(spr_pkg::ADDR_CONFIG, {20'h0, 4'hF, 2'b0, 2'b11, 2'b11, 2'(p)}, 0);
            for (int k = 0; k < 4; k++) begin
                v = (p == 1) ? ((k == 0) ? 500 : (k == 2) ? 3500 : 2000)
                             : ((k == 0) ? 3500 : (k == 2) ? 500 : 2000);
                rdg(v);
                rd(spr_pkg::ADDR_STATUS, (k < 2) ? 32'h11 : 32'h0, 32'h11, 0);
            end
        end
        lock_n <= 0;
        wr(spr_pkg::ADDR_LEVEL1, 32'd2000, 1);
        rd(spr_pkg::ADDR_LEVEL1, 32'd1000, 32'h0000_FFFF, 0);
        lock_n <= 1;
        dim_n <= 0;
        settle();
        chk("dimmed brightness", 32'd1, 32'(brite));
        @(posedge sys_clk);
        dim_n <= 1;
        wr(spr_pkg::ADDR_CONFIG, {20'h0, 4'hF, 2'b0, 2'b11, 2'b00, 2'd0}, 0);
        settle();
        chk("display blanked", 32'h0, 32'(numeric_display_on_on));
        @(posedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            program_key <= 1;
            @(posedge sys_clk);
            program_key <= 0;
            settle();
            chk("prompt", (i == 8) ? 32'h1 : 32'h2 << i, 32'(prompt));
            if (i == 0) chk("display lit", 32'h1, 32'(numeric_display_on_on));
            @(posedge sys_clk);
        end
        settle();
        chk("display reblanked", 32'h0, 32'(numeric_display_on_on));
        @(posedge sys_clk);
        view_key <= 1;
        @(posedge sys_clk);
        view_key <= 0;
        settle();
        chk("display viewing", 32'h1, 32'(numeric_display_on_on));
        end_of_test();
    end
endmodule
